// ---- logic/ccp_converter_control.sv ----
// Summary of operation
// - Results always 12 bit, internal reference only
// - Mode bit 0 converts continuously at rate
// - Continuous results overwrite result register, deferred while a read pair is open
// - Mode 1 samples once per trigger write
// - One-shot trigger reads busy; writing 0 ignored
// - One-shot completion sets selected port event bit
// - Continuous trigger write 1 starts, 0 stops
// - Rate field picks 10/12.5/15/20 K samples
// - Arm bit write 1 arms, 0 disarms
// - Code 01 while armed activates charge pump
// - Other codes leave pump unchanged, clear arm
// - Unlock field ignored while arm is 0
// - Unlock field reads 00 active, 01 inactive
// - Port bit selects port 0 or 1
// - Result held stable during two-byte read
// - Clock gate stops converter, registers inaccessible
// - Only port role 10 on P0/P1 converts
// - Events reported on port zero/one bits
`timescale 1ns/1ns
`default_nettype none
module ccp_converter_control #(
	parameter int unsigned SAMPLE_CYC_00 =
		ccp_pkg::CLK_HZ / ccp_pkg::RATE_SPS_00,
	parameter int unsigned SAMPLE_CYC_01 =
		ccp_pkg::CLK_HZ / ccp_pkg::RATE_SPS_01,
	parameter int unsigned SAMPLE_CYC_10 =
		ccp_pkg::CLK_HZ / ccp_pkg::RATE_SPS_10,
	parameter int unsigned SAMPLE_CYC_11 =
		ccp_pkg::CLK_HZ / ccp_pkg::RATE_SPS_11,
	parameter int unsigned TIMER_W       = 16
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	// Register access, one byte per strobe
	input  wire logic        i_wr_en,
	input  wire logic        i_rd_en,
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	output logic      [7:0]  o_rdata,
	// System context
	input  wire logic        i_conv_clock_off,
	input  wire logic [1:0]  i_port0_role,
	input  wire logic [1:0]  i_port1_role,
	// Analog converter handshake
	output logic             o_conv_start,
	output logic             o_conv_channel,
	input  wire logic        i_conv_done,
	input  wire logic [11:0] i_conv_data,
	// Charge pump
	output logic             o_pump_enable,
	// Interrupt status set pulses
	output logic             o_port_zero_event,
	output logic             o_port_one_event
);

	localparam logic [TIMER_W-1:0] PER_00 = TIMER_W'(SAMPLE_CYC_00 - 1);
	localparam logic [TIMER_W-1:0] PER_01 = TIMER_W'(SAMPLE_CYC_01 - 1);
	localparam logic [TIMER_W-1:0] PER_10 = TIMER_W'(SAMPLE_CYC_10 - 1);
	localparam logic [TIMER_W-1:0] PER_11 = TIMER_W'(SAMPLE_CYC_11 - 1);
	localparam int unsigned        PMAX   = 2 ** TIMER_W;

	if (TIMER_W > 31 || SAMPLE_CYC_00 < 2 || SAMPLE_CYC_00 > PMAX ||
		SAMPLE_CYC_01 < 2 || SAMPLE_CYC_01 > PMAX ||
		SAMPLE_CYC_10 < 2 || SAMPLE_CYC_10 > PMAX ||
		SAMPLE_CYC_11 < 2 || SAMPLE_CYC_11 > PMAX) begin : g_bad_param
		$error("sample period does not fit the timer");
	end

	// Address match, used by both groups
	function automatic logic addr_is(input logic [7:0] a,
		input logic [7:0] ref_addr);
		addr_is = (a == ref_addr);
	endfunction : addr_is

	// Converter input role of the chosen port
	function automatic logic port_ok(input logic sel,
		input logic [1:0] r0, input logic [1:0] r1);
		if (sel) begin
			port_ok = (r1 == ccp_pkg::ROLE_CONV);
		end else begin
			port_ok = (r0 == ccp_pkg::ROLE_CONV);
		end
	endfunction : port_ok

	// Control and conversion state
	logic                  mode;
	logic                  next_mode;
	logic                  trig;
	logic                  next_trig;
	logic [1:0]            rate;
	logic [1:0]            next_rate;
	logic                  arm;
	logic                  next_arm;
	logic                  next_pump;
	logic                  port;
	logic                  next_port;
	ccp_pkg::ccp_state_e   state;
	ccp_pkg::ccp_state_e   next_state;
	logic [TIMER_W-1:0]    timer;
	logic [TIMER_W-1:0]    next_timer;
	logic [TIMER_W-1:0]    period;
	logic                  tick;
	logic                  next_start;
	logic                  next_chan;
	logic                  next_ev0;
	logic                  next_ev1;
	logic                  res_load;
	logic                  wr_ctrl;
	// Read side state
	logic                  rd_hi;
	logic                  next_rd_hi;
	logic                  rd_lo;
	logic                  next_rd_lo;
	logic [7:0]            next_rdata;
	logic                  freeze;
	logic                  release_rd;
	logic [ccp_pkg::REG_W-1:0] shown;
	logic [ccp_pkg::REG_W-1:0] res_word;

	assign wr_ctrl = i_wr_en && !i_conv_clock_off &&
		addr_is(i_addr, ccp_pkg::ADDR_CTRL);

	assign res_word = {{(ccp_pkg::REG_W - ccp_pkg::RES_W){1'b0}},
		i_conv_data};

	always_comb begin
		case (rate)
			2'h0: period = PER_00;
			2'h1: period = PER_01;
			2'h2: period = PER_10;
			default: period = PER_11;
		endcase
	end

	always_comb begin
		next_mode  = mode;
		next_trig  = trig;
		next_rate  = rate;
		next_arm   = arm;
		next_pump  = o_pump_enable;
		next_port  = port;
		next_state = state;
		next_timer = timer;
		next_chan  = o_conv_channel;
		next_start = 1'b0;
		next_ev0   = 1'b0;
		next_ev1   = 1'b0;
		res_load   = 1'b0;
		tick       = 1'b0;
		// Gated clock freezes everything
		if (!i_conv_clock_off) begin
			if (mode == ccp_pkg::MODE_CONT && trig) begin
				if (timer >= period) begin
					next_timer = '0;
					tick       = 1'b1;
				end else begin
					next_timer = timer + 1'b1;
				end
			end else begin
				next_timer = '0;
			end
			case (state)
				ccp_pkg::CCP_IDLE: begin
					if (port_ok(port, i_port0_role, i_port1_role) &&
						((mode == ccp_pkg::MODE_ONESHOT && trig) ||
						tick)) begin
						next_state = ccp_pkg::CCP_CONVERT;
						next_start = 1'b1;
						next_chan  = port;
					end
				end
				ccp_pkg::CCP_CONVERT: begin
					if (i_conv_done) begin
						next_state = ccp_pkg::CCP_IDLE;
						res_load   = 1'b1;
						if (mode == ccp_pkg::MODE_ONESHOT) begin
							next_trig = 1'b0;
							next_ev0  = !o_conv_channel;
							next_ev1  = o_conv_channel;
						end
					end
				end
				default: begin
					next_state = ccp_pkg::CCP_IDLE;
				end
			endcase
			if (wr_ctrl) begin
				next_mode = i_wdata[ccp_pkg::BIT_MODE];
				next_rate = i_wdata[ccp_pkg::RATE_HI:ccp_pkg::RATE_LO];
				next_port = i_wdata[ccp_pkg::BIT_PORT];
				if (i_wdata[ccp_pkg::BIT_MODE] == ccp_pkg::MODE_ONESHOT &&
					mode == ccp_pkg::MODE_ONESHOT) begin
					// Write 1 starts, write 0 leaves busy flag
					if (i_wdata[ccp_pkg::BIT_TRIG] &&
						port_ok(i_wdata[ccp_pkg::BIT_PORT],
						i_port0_role, i_port1_role)) begin
						next_trig = 1'b1;
					end
				end else begin
					next_trig = i_wdata[ccp_pkg::BIT_TRIG];
				end
				if (arm) begin
					if (i_wdata[ccp_pkg::CODE_HI:ccp_pkg::CODE_LO] ==
						ccp_pkg::UNLOCK_CODE) begin
						next_pump = 1'b1;
						next_arm  = i_wdata[ccp_pkg::BIT_ARM];
					end else begin
						next_arm = 1'b0;
					end
				end else begin
					next_arm = i_wdata[ccp_pkg::BIT_ARM];
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mode              <= ccp_pkg::CTRL_RESET[ccp_pkg::BIT_MODE];
			trig              <= ccp_pkg::CTRL_RESET[ccp_pkg::BIT_TRIG];
			rate              <=
				ccp_pkg::CTRL_RESET[ccp_pkg::RATE_HI:ccp_pkg::RATE_LO];
			arm               <= ccp_pkg::CTRL_RESET[ccp_pkg::BIT_ARM];
			o_pump_enable     <= 1'b0;
			port              <= ccp_pkg::CTRL_RESET[ccp_pkg::BIT_PORT];
			state             <= ccp_pkg::CCP_IDLE;
			timer             <= '0;
			o_conv_start      <= 1'b0;
			o_conv_channel    <= 1'b0;
			o_port_zero_event <= 1'b0;
			o_port_one_event  <= 1'b0;
		end else begin
			mode              <= next_mode;
			trig              <= next_trig;
			rate              <= next_rate;
			arm               <= next_arm;
			o_pump_enable     <= next_pump;
			port              <= next_port;
			state             <= next_state;
			timer             <= next_timer;
			o_conv_start      <= next_start;
			o_conv_channel    <= next_chan;
			o_port_zero_event <= next_ev0;
			o_port_one_event  <= next_ev1;
		end
	end

	// Result held stable across a byte pair read
	ccp_result_hold #(
		.WIDTH (ccp_pkg::REG_W)
	) u_hold (
		.i_clk     (i_clk),
		.i_arst_n  (i_arst_n),
		.i_load    (res_load),
		.i_data    (res_word),
		.i_freeze  (freeze),
		.i_release (release_rd),
		.o_data    (shown)
	);

	always_comb begin
		next_rd_hi = rd_hi;
		next_rd_lo = rd_lo;
		next_rdata = o_rdata;
		freeze     = 1'b0;
		release_rd = 1'b0;
		if (!i_conv_clock_off && (i_rd_en || i_wr_en)) begin
			if (!addr_is(i_addr, ccp_pkg::ADDR_RES_HI) &&
				!addr_is(i_addr, ccp_pkg::ADDR_RES_LO)) begin
				release_rd = rd_hi || rd_lo;
				next_rd_hi = 1'b0;
				next_rd_lo = 1'b0;
			end else if (i_rd_en) begin
				freeze = !(rd_hi || rd_lo);
				if (addr_is(i_addr, ccp_pkg::ADDR_RES_HI)) begin
					next_rd_hi = 1'b1;
				end else begin
					next_rd_lo = 1'b1;
				end
				if (next_rd_hi && next_rd_lo) begin
					release_rd = 1'b1;
					next_rd_hi = 1'b0;
					next_rd_lo = 1'b0;
				end
			end
		end
		if (i_rd_en) begin
			if (i_conv_clock_off) begin
				next_rdata = 8'h00;
			end else if (addr_is(i_addr, ccp_pkg::ADDR_CTRL)) begin
				next_rdata = {mode, trig, rate, arm,
					o_pump_enable ? ccp_pkg::RD_PUMP_ON :
					ccp_pkg::RD_PUMP_OFF, port};
			end else if (addr_is(i_addr, ccp_pkg::ADDR_RES_HI)) begin
				next_rdata = shown[15:8];
			end else if (addr_is(i_addr, ccp_pkg::ADDR_RES_LO)) begin
				next_rdata = shown[7:0];
			end else begin
				next_rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rd_hi   <= 1'b0;
			rd_lo   <= 1'b0;
			o_rdata <= 8'h00;
		end else begin
			rd_hi   <= next_rd_hi;
			rd_lo   <= next_rd_lo;
			o_rdata <= next_rdata;
		end
	end

endmodule : ccp_converter_control
`default_nettype wire

// ---- shared/ccp_pkg.sv ----
`default_nettype none
package ccp_pkg;

	// System clock and converter sample rates
	localparam int unsigned CLK_HZ      = 100_000_000;
	localparam int unsigned RATE_SPS_00 = 10_000;
	localparam int unsigned RATE_SPS_01 = 12_500;
	localparam int unsigned RATE_SPS_10 = 15_000;
	localparam int unsigned RATE_SPS_11 = 20_000;

	// Register addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h20;
	localparam logic [7:0] ADDR_RES_HI = 8'h21;
	localparam logic [7:0] ADDR_RES_LO = 8'h22;

	// Control register layout and reset value
	localparam logic [7:0] CTRL_RESET = 8'h32;
	localparam int unsigned BIT_MODE  = 7;
	localparam int unsigned BIT_TRIG  = 6;
	localparam int unsigned RATE_HI   = 5;
	localparam int unsigned RATE_LO   = 4;
	localparam int unsigned BIT_ARM   = 3;
	localparam int unsigned CODE_HI   = 2;
	localparam int unsigned CODE_LO   = 1;
	localparam int unsigned BIT_PORT  = 0;

	// Field codes
	localparam logic       MODE_CONT     = 1'b0;
	localparam logic       MODE_ONESHOT  = 1'b1;
	localparam logic [1:0] UNLOCK_CODE   = 2'h1;
	localparam logic [1:0] RD_PUMP_ON    = 2'h0;
	localparam logic [1:0] RD_PUMP_OFF   = 2'h1;
	localparam logic [1:0] ROLE_CONV     = 2'h2;

	// Result widths
	localparam int unsigned RES_W = 12;
	localparam int unsigned REG_W = 16;

	typedef enum logic [1:0] {
		CCP_IDLE    = 2'b00,
		CCP_CONVERT = 2'b01
	} ccp_state_e;

endpackage : ccp_pkg
`default_nettype wire

// ---- logic/ccp_result_hold.sv ----
`timescale 1ns/1ns
`default_nettype none
module ccp_result_hold #(
	parameter int unsigned WIDTH = 16
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_arst_n,
	// New result
	input  wire logic             i_load,
	input  wire logic [WIDTH-1:0] i_data,
	// Read lock control
	input  wire logic             i_freeze,
	input  wire logic             i_release,
	// Visible result
	output logic      [WIDTH-1:0] o_data
);

	logic [WIDTH-1:0] pend;
	logic [WIDTH-1:0] next_pend;
	logic [WIDTH-1:0] next_data;
	logic             pend_v;
	logic             next_pend_v;
	logic             held;
	logic             next_held;

	always_comb begin
		next_data   = o_data;
		next_pend   = pend;
		next_pend_v = pend_v;
		next_held   = held;
		if (i_release) begin
			next_held = 1'b0;
			if (pend_v) begin
				next_data   = pend;
				next_pend_v = 1'b0;
			end
		end else if (i_freeze) begin
			next_held = 1'b1;
		end
		// Deferred while a read pair is open
		if (i_load) begin
			if (next_held) begin
				next_pend   = i_data;
				next_pend_v = 1'b1;
			end else begin
				next_data   = i_data;
				next_pend_v = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_data <= '0;
			pend   <= '0;
			pend_v <= 1'b0;
			held   <= 1'b0;
		end else begin
			o_data <= next_data;
			pend   <= next_pend;
			pend_v <= next_pend_v;
			held   <= next_held;
		end
	end

endmodule : ccp_result_hold
`default_nettype wire

// ---- verification/ccp_conv_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ccp_conv_model (
	// Clock and reset
	input	wire logic	i_clk,
	input	wire logic	i_arst_n,
	// Converter handshake
	input	wire logic	i_start,
	input	wire logic [3:0]	i_delay,
	input	wire logic [11:0]	i_value,
	output	logic	o_done,
	output	logic [11:0]	o_data
);
	logic [3:0]	cnt;
	logic	busy;
	logic [11:0]	val;
	always @(posedge i_clk or negedge i_arst_n) begin
		o_done <= 1'b0;
		o_data <= ~o_data;
		if (!i_arst_n) begin
			busy <= 1'b0;
			o_data <= 12'h5a5;
		end else if (i_start) begin
			busy <= 1'b1;
			cnt <= i_delay;
			val <= i_value;
		end else if (busy && cnt == 4'h0) begin
			busy <= 1'b0;
			o_done <= 1'b1;
			o_data <= val;
		end else begin
			cnt <= cnt - 4'h1;
		end
	end
endmodule : ccp_conv_model
`default_nettype wire

// ---- verification/ccp_converter_control_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module ccp_converter_control_asserts (
	// Watched ports
	input	wire logic	i_clk,
	input	wire logic	i_arst_n,
	input	wire logic	i_wr_en,
	input	wire logic	i_rd_en,
	input	wire logic [7:0]	i_addr,
	input	wire logic [7:0]	i_wdata,
	input	wire logic [7:0]	o_rdata,
	input	wire logic	i_conv_clock_off,
	input	wire logic [1:0]	i_port0_role,
	input	wire logic [1:0]	i_port1_role,
	input	wire logic	o_conv_start,
	input	wire logic	o_conv_channel,
	input	wire logic	i_conv_done,
	input	wire logic	o_pump_enable,
	input	wire logic	o_port_zero_event,
	input	wire logic	o_port_one_event
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	sequence s_hi_read;
		i_rd_en && !i_conv_clock_off && i_addr == ccp_pkg::ADDR_RES_HI;
	endsequence
	property p_res_upper; s_hi_read |=> o_rdata[7:4] == 4'h0; endproperty
	a_res_upper: assert property (p_res_upper)
		else $error("result upper bits not zero");
	property p_ev0;
		o_port_zero_event |-> $past(i_conv_done) && !$past(o_conv_channel);
	endproperty
	a_ev0: assert property (p_ev0)
		else $error("port zero event without done");
	property p_ev1;
		o_port_one_event |-> $past(i_conv_done) && $past(o_conv_channel);
	endproperty
	a_ev1: assert property (p_ev1)
		else $error("port one event without done");
	property p_ev_excl; !(o_port_zero_event && o_port_one_event); endproperty
	a_ev_excl: assert property (p_ev_excl)
		else $error("both event pulses");
	property p_start_pulse; o_conv_start |=> !o_conv_start; endproperty
	a_start_pulse: assert property (p_start_pulse)
		else $error("start longer than one cycle");
	property p_start_role;
		o_conv_start |->
			(o_conv_channel ? $past(i_port1_role) : $past(i_port0_role))
			== ccp_pkg::ROLE_CONV;
	endproperty
	a_start_role: assert property (p_start_role)
		else $error("start on non converter port");
	property p_pump_keep; o_pump_enable |=> o_pump_enable; endproperty
	a_pump_keep: assert property (p_pump_keep)
		else $error("pump dropped");
	property p_pump_cause;
		$rose(o_pump_enable) |-> $past(i_wr_en) &&
			$past(i_addr) == ccp_pkg::ADDR_CTRL && ($past(i_wdata) & 8'h06) == 8'h02;
	endproperty
	a_pump_cause: assert property (p_pump_cause)
		else $error("pump on without unlock write");
	property p_rd_hold; !$past(i_rd_en) |-> $stable(o_rdata); endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data moved without read");
	property p_off_read; i_rd_en && i_conv_clock_off |=> o_rdata == 8'h00; endproperty
	a_off_read: assert property (p_off_read)
		else $error("read while gated not zero");
endmodule : ccp_converter_control_asserts
bind ccp_converter_control ccp_converter_control_asserts i_chk (.i_clk, .i_arst_n,
	.i_wr_en, .i_rd_en, .i_addr, .i_wdata, .o_rdata, .i_conv_clock_off,
	.i_port0_role, .i_port1_role, .o_conv_start, .o_conv_channel,
	.i_conv_done, .o_pump_enable, .o_port_zero_event, .o_port_one_event);
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic	i_clk = 1'b0;
	logic	i_arst_n = 1'b0;
	logic	i_wr_en = 1'b0;
	logic	i_rd_en = 1'b0;
	logic [7:0]	i_addr = 8'h00;
	logic [7:0]	i_wdata = 8'h00;
	logic	i_conv_clock_off = 1'b0;
	logic [1:0]	i_port0_role = 2'h2;
	logic [1:0]	i_port1_role = 2'h2;
	logic	o_conv_start, o_conv_channel, i_conv_done, o_pump_enable;
	logic	o_port_zero_event, o_port_one_event, slow = 1'b1, p;
	logic [7:0]	o_rdata, d, h;
	logic [3:0]	dly = 4'h0;
	logic [11:0]	i_conv_data, val = 12'h000, last = 12'h000, snap, t;
	int	fails = 0, checked = 0, starts = 0, ev0 = 0, ev1 = 0;
	int	ncyc = 0, t0 = 0, per = 0, s, e0, e1;
	int	cyc[4] = '{20, 16, 13, 10};

	ccp_converter_control #(.SAMPLE_CYC_00(20), .SAMPLE_CYC_01(16),
		.SAMPLE_CYC_10(13), .SAMPLE_CYC_11(10)) i_ccp_converter_control (
		.i_clk, .i_arst_n, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .o_rdata,
		.i_conv_clock_off, .i_port0_role, .i_port1_role, .o_conv_start,
		.o_conv_channel, .i_conv_done, .i_conv_data, .o_pump_enable,
		.o_port_zero_event, .o_port_one_event);
	ccp_conv_model i_ccp_conv_model (.i_clk, .i_arst_n, .i_start(o_conv_start),
		.i_delay(dly), .i_value(val), .o_done(i_conv_done), .o_data(i_conv_data));

	always #5 i_clk = ~i_clk;
	// Bench-side observation of starts, events and loaded results
	always @(posedge i_clk) begin
		ncyc <= ncyc + 1;
		// Short enough that no tick is dropped at the fastest rate
		dly <= slow ? 4'hf : 4'($urandom_range(5));
		val <= 12'($urandom);
		if (i_conv_done) last <= i_conv_data;
		if (o_port_zero_event) ev0 <= ev0 + 1;
		if (o_port_one_event) ev1 <= ev1 + 1;
		if (o_conv_start) begin
			starts <= starts + 1;
			per <= ncyc - t0;
			t0 <= ncyc;
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		i_addr <= a;
		i_wdata <= v;
		i_wr_en <= 1'b1;
		@(posedge i_clk);
		i_wr_en <= 1'b0;
		@(posedge i_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		i_addr <= a;
		i_rd_en <= 1'b1;
		@(posedge i_clk);
		snap = last;
		i_rd_en <= 1'b0;
		@(posedge i_clk);
		d = o_rdata;
	endtask : rd
	task automatic complete_run;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (20000) @(posedge i_clk);
		fails++;
		complete_run();
	end
	initial begin
		void'($urandom(88));
		repeat (3) @(posedge i_clk);
		i_arst_n <= 1'b1;
		@(posedge i_clk);
		rd(8'h20); chk(d, 8'h32);
		rd(8'h21); chk(d, 8'h00);
		rd(8'h23); chk(d, 8'h00);
		i_conv_clock_off <= 1'b1;
		wr(8'h20, 8'h81);
		rd(8'h20); chk(d, 8'h00);
		i_conv_clock_off <= 1'b0;
		rd(8'h20); chk(d, 8'h32);
		$display("test reset and gate done");
		for (int k = 0; k < 4; k++) begin
			p = k[0];
			wr(8'h20, {7'h40, p});
			e0 = ev0;
			e1 = ev1;
			s = starts;
			wr(8'h20, {7'h60, p});
			rd(8'h20); chk(d[6], 1'b1);
			wr(8'h20, {7'h40, p});
			rd(8'h20); chk(d[6], 1'b1);
			for (int w = 0; w < 40 && ev0 + ev1 == e0 + e1; w++) @(posedge i_clk);
			@(posedge i_clk);
			chk(16'((ev1 - e1) * 2 + ev0 - e0), p ? 16'h2 : 16'h1);
			chk(16'(starts - s), 16'h1);
			chk(o_conv_channel, p);
			rd(8'h20); chk(d[6], 1'b0);
			rd(8'h21); h = d;
			rd(8'h22); chk({h, d}, {4'h0, snap});
		end
		for (int r = 0; r < 4; r++) begin
			if (r != 2) begin
				i_port0_role <= 2'(r);
				s = starts;
				wr(8'h20, 8'hc0);
				repeat (20) @(posedge i_clk);
				chk(16'(starts - s), 16'h0);
				rd(8'h20); chk(d[6], 1'b0);
			end
		end
		i_port0_role <= 2'h2;
		$display("test one-shot done");
		slow <= 1'b0;
		e0 = ev0 + ev1;
		for (int r = 0; r < 4; r++) begin
			wr(8'h20, {2'b01, 2'(r), 4'h0});
			s = starts;
			for (int w = 0; w < 100 && starts < s + 3; w++) @(posedge i_clk);
			chk(16'(per), 16'(cyc[r]));
		end
		rd(8'h21); h = d; t = snap;
		repeat (35) @(posedge i_clk);
		rd(8'h22); chk({h, d}, {4'h0, t});
		rd(8'h21); h = d; t = snap;
		rd(8'h22); chk({h, d}, {4'h0, t});
		rd(8'h21);
		repeat (35) @(posedge i_clk);
		rd(8'h20);
		rd(8'h22); chk(d, snap[7:0]);
		wr(8'h20, 8'h30);
		repeat (2) @(posedge i_clk);
		s = starts;
		repeat (40) @(posedge i_clk);
		chk(16'(starts - s), 16'h0);
		chk(16'(ev0 + ev1 - e0), 16'h0);
		$display("test continuous done");
		wr(8'h20, 8'h02);
		rd(8'h20); chk(d[3:1], 3'b001);
		for (int c = 0; c < 4; c++) begin
			if (c != 1) begin
				wr(8'h20, 8'h08);
				rd(8'h20); chk(d[3:1], 3'b101);
				wr(8'h20, {4'h0, 1'b1, 2'(c), 1'b0});
				rd(8'h20); chk(d[3:1], 3'b001);
				chk(o_pump_enable, 1'b0);
			end
		end
		wr(8'h20, 8'h08);
		wr(8'h20, 8'h02);
		chk(o_pump_enable, 1'b1);
		rd(8'h20); chk(d[2:1], 2'b00);
		i_arst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_arst_n <= 1'b1;
		@(posedge i_clk);
		chk(o_pump_enable, 1'b0);
		rd(8'h20); chk(d, 8'h32);
		$display("test pump done");
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
